/* hdl/xfer_consts.svh */
// offsets, field positions, reset values and limits of the byte transfer decoder
// Summary of operation
// RULE1: indirect operand length: register-indirect 1 or 2, based 3, indexed 5, based-indexed 2
// RULE2: one-byte indirect only for byte transfer via pointer six or seven, plain/inc/dec
// RULE3: edge pages or group one give shorter length; mid page or group two longer
// RULE4: each flag is kept, cleared, set, taken from result, or restored from saved copy
// RULE5: parity/overflow flag shows parity or signed overflow as the instruction selects
// RULE6: branch target is next instruction start plus signed 8- or 16-bit offset
// RULE7: a 16-bit pointer short name still selects the full 24-bit pointer register
// RULE8: mid page FE00H-FEFFH; edge pages FD20H-FDFFH and FF00H-FF1FH pick the length
// RULE9: byte transfer into flags low byte replaces all flags; other transfers keep them
`ifndef XFER_CONSTS_SVH
`define XFER_CONSTS_SVH
// ***********************************
// register offsets
// ***********************************
`define OFS_CTRL 8'h00
`define OFS_SADDR 8'h04
`define OFS_IADDR 8'h08
`define OFS_DISP 8'h0c
`define OFS_FACT 8'h10
`define OFS_FOP 8'h14
`define OFS_XFER 8'h18
`define OFS_SAVED 8'h1c
`define OFS_LEN 8'h20
`define OFS_TARGET 8'h24
`define OFS_PTR_EFF 8'h28
`define OFS_PSW 8'h2c
`define OFS_PTR0 8'h30
`define OFS_PTR3 8'h3c
// ***********************************
// control fields
// ***********************************
`define CTRL_FORM_LSB 0
`define CTRL_PSEL_LSB 3
`define CTRL_SHORT_NAME 5
`define CTRL_PMOD_LSB 6
`define CTRL_BYTE_OP 8
`define CTRL_GRP_TWO 9
`define CTRL_LONG_DISP 10
`define CTRL_DEST_LSB 11
`define CTRL_BASE_LSB 13
// ***********************************
// flag positions in the low status byte, the flag operation data and the action word
// ***********************************
`define FLG_CARRY 0
`define FLG_PV 2
`define FLG_AUX 4
`define FLG_Z 6
`define FLG_S 7
`define FOP_OVF 8
`define FOP_AUX 9
`define FOP_CARRY 10
`define FACT_PV_PARITY 15
// ***********************************
// lengths and short-direct pages
// ***********************************
`define LEN_RI_SHORT 3'h1
`define LEN_RI_LONG 3'h2
`define LEN_BASED 3'h3
`define LEN_INDEXED 3'h5
`define LEN_BASED_IDX 3'h2
`define SD_EDGE_LO_MIN 16'hfd20
`define SD_EDGE_LO_MAX 16'hfdff
`define SD_MID_MIN 16'hfe00
`define SD_MID_MAX 16'hfeff
`define SD_EDGE_HI_MIN 16'hff00
`define SD_EDGE_HI_MAX 16'hff1f
// ***********************************
// reset values and bus answers
// ***********************************
`define RST_CTRL 32'h0000_0000
`define RST_PSW 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* hdl/xfer_pkg.sv */
// types shared by the byte transfer decoder modules
package xfer_pkg;
  typedef enum logic [2:0] {FORM_REG_IND, FORM_BASED, FORM_INDEXED, FORM_BASED_IDX,
                            FORM_SADDR, FORM_REG, FORM_FIXED} form_t;
  typedef enum logic [1:0] {PTR_SIX, PTR_SEVEN, PTR_BASE, PTR_USER} ptr_t;
  typedef enum logic [1:0] {PMOD_PLAIN, PMOD_INC, PMOD_DEC, PMOD_OFS} pmod_t;
  typedef enum logic [1:0] {DEST_OTHER, DEST_FLAGS_LOW, DEST_FLAGS_HIGH, DEST_RSVD} dest_t;
  typedef enum logic [2:0] {FA_KEEP, FA_CLR, FA_SET, FA_RESULT, FA_RESTORE} fact_t;
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [15:0] saddr;
    logic [23:0] iaddr;
    logic [15:0] disp;
    logic [15:0] fact;
    logic [7:0] saved;
    logic [7:0] psw_lo;
    logic [7:0] psw_hi;
    logic [3:0][23:0] ptr;
  } state_t;
endpackage : xfer_pkg

/* hdl/xfer_if.sv */
// carrier between the decoder core and its length and flag helpers
`timescale 1ns/1ps
`default_nettype none
interface xfer_if;
  import xfer_pkg::*;
  form_t form;
  ptr_t psel;
  pmod_t pmod;
  logic byte_op;
  logic grp_two;
  logic [15:0] saddr;
  logic [2:0] base_len;
  logic [2:0] len;
  logic illegal;
  logic [7:0] flags_in;
  logic [7:0] saved;
  logic [15:0] fact;
  logic [7:0] result;
  logic ovf;
  logic aux_in;
  logic carry_in;
  logic [7:0] flags_out;
  modport core (output form, psel, pmod, byte_op, grp_two, saddr, base_len,
                output flags_in, saved, fact, result, ovf, aux_in, carry_in,
                input len, illegal, flags_out);
  modport len_mp (input form, psel, pmod, byte_op, grp_two, saddr, base_len,
                  output len, illegal);
  modport flag_mp (input flags_in, saved, fact, result, ovf, aux_in, carry_in,
                   output flags_out);
endinterface : xfer_if
`default_nettype wire

/* hdl/mem_len_decode.sv */
// instruction length from addressing form, pointer and operand page
`timescale 1ns/1ps
`default_nettype none
`include "xfer_consts.svh"
module mem_len_decode
  import xfer_pkg::*;
(
  xfer_if.len_mp lif
);
  logic edge_pg;
  logic mid_pg;
  logic one_byte_ok;
  always_comb begin
    edge_pg = (lif.saddr >= `SD_EDGE_LO_MIN && lif.saddr <= `SD_EDGE_LO_MAX) ||
              (lif.saddr >= `SD_EDGE_HI_MIN && lif.saddr <= `SD_EDGE_HI_MAX); // RULE8
    mid_pg = lif.saddr >= `SD_MID_MIN && lif.saddr <= `SD_MID_MAX; // RULE8
    one_byte_ok = lif.byte_op && (lif.psel == PTR_SIX || lif.psel == PTR_SEVEN) &&
                  lif.pmod != PMOD_OFS; // RULE2
    lif.illegal = 1'b0;
    unique case (lif.form)
      FORM_REG_IND: lif.len = one_byte_ok ? `LEN_RI_SHORT : `LEN_RI_LONG; // RULE1
      FORM_BASED: lif.len = `LEN_BASED; // RULE1
      FORM_INDEXED: lif.len = `LEN_INDEXED; // RULE1
      FORM_BASED_IDX: lif.len = `LEN_BASED_IDX; // RULE1
      FORM_SADDR: begin
        // outside both page sets the operand cannot be short-direct at all
        lif.illegal = !(edge_pg || mid_pg);
        lif.len = lif.base_len + {2'h0, mid_pg}; // RULE3
      end
      FORM_REG: lif.len = lif.base_len + {2'h0, lif.grp_two}; // RULE3
      FORM_FIXED: lif.len = lif.base_len;
      default: begin
        lif.len = 3'h0;
        lif.illegal = 1'b1;
      end
    endcase
  end
endmodule : mem_len_decode
`default_nettype wire

/* hdl/flag_unit.sv */
// per-flag update of the low status byte
`timescale 1ns/1ps
`default_nettype none
`include "xfer_consts.svh"
module flag_unit
  import xfer_pkg::*;
(
  xfer_if.flag_mp fif
);
  function automatic logic upd(input logic [2:0] act, input logic cur,
                               input logic res, input logic sav);
    unique case (act)
      FA_KEEP: upd = cur; // RULE4
      FA_CLR: upd = 1'b0; // RULE4
      FA_SET: upd = 1'b1; // RULE4
      FA_RESULT: upd = res; // RULE4
      FA_RESTORE: upd = sav; // RULE4
      default: upd = cur;
    endcase
  endfunction : upd
  logic pv_res;
  always_comb begin
    // parity flag set on even parity of the result
    pv_res = fif.fact[`FACT_PV_PARITY] ? ~^fif.result : fif.ovf; // RULE5
    fif.flags_out = fif.flags_in;
    fif.flags_out[`FLG_CARRY] = upd(fif.fact[2:0], fif.flags_in[`FLG_CARRY], fif.carry_in,
                                    fif.saved[`FLG_CARRY]);
    fif.flags_out[`FLG_PV] = upd(fif.fact[5:3], fif.flags_in[`FLG_PV], pv_res,
                                 fif.saved[`FLG_PV]);
    fif.flags_out[`FLG_AUX] = upd(fif.fact[8:6], fif.flags_in[`FLG_AUX], fif.aux_in,
                                  fif.saved[`FLG_AUX]);
    fif.flags_out[`FLG_Z] = upd(fif.fact[11:9], fif.flags_in[`FLG_Z], fif.result == 8'h00,
                                fif.saved[`FLG_Z]);
    fif.flags_out[`FLG_S] = upd(fif.fact[14:12], fif.flags_in[`FLG_S], fif.result[7],
                                fif.saved[`FLG_S]);
  end
endmodule : flag_unit
`default_nettype wire

/* hdl/byte_transfer_decode.sv */
// byte transfer decode core with its AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "xfer_consts.svh"
module byte_transfer_decode
  import xfer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ***********************************
  // state and helpers
  // ***********************************
  state_t st_r;
  state_t st_nxt;
  xfer_if xif ();

  mem_len_decode u_len (
    .lif(xif)
  );
  flag_unit u_flag (
    .fif(xif)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OFS_PTR3);
  endfunction : mapped

  // ***********************************
  // decode of the current instruction
  // ***********************************
  logic [23:0] next_pc;
  logic [23:0] disp_ext;
  logic [23:0] target;
  logic [23:0] ptr_eff;
  ptr_t psel;

  always_comb begin
    psel = ptr_t'(st_r.ctrl[`CTRL_PSEL_LSB +: 2]);
    xif.form = form_t'(st_r.ctrl[`CTRL_FORM_LSB +: 3]);
    xif.psel = psel;
    xif.pmod = pmod_t'(st_r.ctrl[`CTRL_PMOD_LSB +: 2]);
    xif.byte_op = st_r.ctrl[`CTRL_BYTE_OP];
    xif.grp_two = st_r.ctrl[`CTRL_GRP_TWO];
    xif.saddr = st_r.saddr;
    xif.base_len = st_r.ctrl[`CTRL_BASE_LSB +: 3];
    // the short-name bit changes nothing: all 24 bits are always taken
    ptr_eff = st_r.ptr[psel]; // RULE7
    next_pc = st_r.iaddr + {21'h0, xif.len};
    disp_ext = st_r.ctrl[`CTRL_LONG_DISP] ? {{8{st_r.disp[15]}}, st_r.disp} :
               {{16{st_r.disp[7]}}, st_r.disp[7:0]}; // RULE6
    target = next_pc + disp_ext; // RULE6
  end

  // flag helper result, overflow, aux and carry inputs come from the flag operation write data
  always_comb begin
    xif.flags_in = st_r.psw_lo;
    xif.saved = st_r.saved;
    xif.fact = st_r.fact;
    xif.result = st_r.w_data[7:0];
    xif.ovf = st_r.w_data[`FOP_OVF];
    xif.aux_in = st_r.w_data[`FOP_AUX];
    xif.carry_in = st_r.w_data[`FOP_CARRY];
  end

  // ***********************************
  // read mux
  // ***********************************
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      `OFS_CTRL: rd_val = st_r.ctrl;
      `OFS_SADDR: rd_val = {16'h0000, st_r.saddr};
      `OFS_IADDR: rd_val = {8'h00, st_r.iaddr};
      `OFS_DISP: rd_val = {16'h0000, st_r.disp};
      `OFS_FACT: rd_val = {16'h0000, st_r.fact};
      `OFS_SAVED: rd_val = {24'h000000, st_r.saved};
      `OFS_LEN: rd_val = {28'h0000000, xif.illegal, xif.len};
      `OFS_TARGET: rd_val = {8'h00, target};
      `OFS_PTR_EFF: rd_val = {8'h00, ptr_eff};
      `OFS_PSW: rd_val = {16'h0000, st_r.psw_hi, st_r.psw_lo};
      8'h30, 8'h34, 8'h38, 8'h3c: rd_val = {8'h00, st_r.ptr[s_axi_araddr[3:2]]};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ***********************************
  // next state
  // ***********************************
  logic [31:0] wv;
  logic commit;
  dest_t dest;
  always_comb begin
    st_nxt = st_r;
    wv = 32'h0000_0000;
    dest = dest_t'(st_r.ctrl[`CTRL_DEST_LSB +: 2]);
    commit = st_r.aw_have && st_r.w_have && !st_r.bvalid;
    // address and data are taken in either order and held until both are here
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (commit) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mapped(st_r.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (st_r.aw_addr)
        `OFS_CTRL: st_nxt.ctrl = merge(st_r.ctrl, st_r.w_data, st_r.w_strb);
        `OFS_SADDR: begin
          wv = merge({16'h0000, st_r.saddr}, st_r.w_data, st_r.w_strb);
          st_nxt.saddr = wv[15:0];
        end
        `OFS_IADDR: begin
          wv = merge({8'h00, st_r.iaddr}, st_r.w_data, st_r.w_strb);
          st_nxt.iaddr = wv[23:0];
        end
        `OFS_DISP: begin
          wv = merge({16'h0000, st_r.disp}, st_r.w_data, st_r.w_strb);
          st_nxt.disp = wv[15:0];
        end
        `OFS_FACT: begin
          wv = merge({16'h0000, st_r.fact}, st_r.w_data, st_r.w_strb);
          st_nxt.fact = wv[15:0];
        end
        `OFS_FOP: begin
          // the old flags are saved so a later restore can bring them back
          st_nxt.saved = st_r.psw_lo;
          st_nxt.psw_lo = xif.flags_out; // RULE4
        end
        `OFS_XFER: begin
          if (dest == DEST_FLAGS_LOW) begin
            st_nxt.psw_lo = st_r.w_data[7:0]; // RULE9
          end else if (dest == DEST_FLAGS_HIGH) begin
            st_nxt.psw_hi = st_r.w_data[7:0]; // RULE9
          end
        end
        `OFS_SAVED: begin
          wv = merge({24'h000000, st_r.saved}, st_r.w_data, st_r.w_strb);
          st_nxt.saved = wv[7:0];
        end
        8'h30, 8'h34, 8'h38, 8'h3c: begin
          wv = merge({8'h00, st_r.ptr[st_r.aw_addr[3:2]]}, st_r.w_data, st_r.w_strb);
          st_nxt.ptr[st_r.aw_addr[3:2]] = wv[23:0];
        end
        default: st_nxt.bresp = mapped(st_r.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_val;
      st_nxt.rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    // one write and one read in flight; ready drops while an answer waits
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.ctrl <= `RST_CTRL;
      st_r.psw_lo <= `RST_PSW;
      st_r.psw_hi <= `RST_PSW;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
endmodule : byte_transfer_decode
`default_nettype wire

/* tb/operand_space_model.sv */
// reference model of instruction length as the operand space sees it
`timescale 1ns/1ps
`default_nettype none
`include "xfer_consts.svh"
module operand_space_model (
  input wire logic [31:0] ctrl,
  input wire logic [15:0] saddr,
  output logic [3:0] len
);
  // ***********************************
  // length by form and page
  // ***********************************
  logic mid;
  logic edg;
  always_comb begin
    mid = saddr >= `SD_MID_MIN && saddr <= `SD_MID_MAX;
    edg = (saddr >= `SD_EDGE_LO_MIN && saddr <= `SD_EDGE_LO_MAX) ||
          (saddr >= `SD_EDGE_HI_MIN && saddr <= `SD_EDGE_HI_MAX);
    len = 4'h0;
    case (ctrl[2:0])
      3'h0: len[2:0] = (ctrl[8] && !ctrl[4] && ctrl[7:6] != 2'h3) ?
                       `LEN_RI_SHORT : `LEN_RI_LONG;
      3'h1: len[2:0] = `LEN_BASED;
      3'h2: len[2:0] = `LEN_INDEXED;
      3'h3: len[2:0] = `LEN_BASED_IDX;
      3'h4: begin
        len[2:0] = ctrl[15:13] + {2'h0, mid};
        len[3] = !(mid || edg);
      end
      3'h5: len[2:0] = ctrl[15:13] + {2'h0, ctrl[9]};
      3'h6: len[2:0] = ctrl[15:13];
      // code 7 names no form: length 0 and marked illegal
      default: len = 4'h8;
    endcase
  end
endmodule : operand_space_model
`default_nettype wire

/* tb/byte_transfer_decode_sva.sv */
// assertion checker for the decoder's register bus
`timescale 1ns/1ps
`default_nettype none
`include "xfer_consts.svh"
module byte_transfer_decode_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ***********************************
  // handshake timing and read contents
  // ***********************************
  logic [7:0] rd_addr_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_addr_r <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_r <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence both_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence commit_s;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  wr_answer_a: assert property (both_taken_s |=> commit_s)
    else $error("write answer at wrong cycle");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer at wrong cycle");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
                             s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
                             !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write path not freed");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read path not freed");
  bad_addr_a: assert property (s_axi_rvalid && (rd_addr_r[1:0] != 2'h0 || rd_addr_r > 8'h3c)
                               |-> s_axi_rresp == `RESP_SLVERR)
    else $error("unmapped read not refused");
  len_field_a: assert property (s_axi_rvalid && rd_addr_r == `OFS_LEN |->
                                s_axi_rdata[31:4] == 28'h0 &&
                                (s_axi_rdata[3] || s_axi_rdata[2:0] != 3'h0))
    else $error("length field out of range");
  ptr_width_a: assert property (s_axi_rvalid && rd_addr_r == `OFS_PTR_EFF |->
                                s_axi_rdata[31:24] == 8'h00)
    else $error("pointer wider than 24 bits");
endmodule : byte_transfer_decode_sva
bind byte_transfer_decode byte_transfer_decode_sva sva_i (.core_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);
`default_nettype wire

/* tb/byte_transfer_decode_bench.sv */
// self-checking bench for the byte transfer decoder
`timescale 1ns/1ps
`default_nettype none
`include "xfer_consts.svh"
module byte_transfer_decode_bench;
  // ***********************************
  // stimulus, bus tasks and checks
  // ***********************************
  logic core_clk = 1'h0, rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  // answer ready lines rise after a random wait so held answers get exercised
  logic s_axi_bready = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] m_ctrl = 32'h0, seed = 32'hb0b1;
  logic [15:0] m_saddr = 16'h0;
  logic [3:0] m_len;
  int checks = 0, fail_count = 0;
  always #12.5 core_clk = ~core_clk;
  byte_transfer_decode DUT (.core_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  operand_space_model model_i (.ctrl(m_ctrl), .saddr(m_saddr), .len(m_len));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [23:0] tgt(input logic [23:0] ia, input logic [15:0] dp,
                                      input logic [2:0] ln, input logic lg);
    return ia + {21'h0, ln} + (lg ? {{8{dp[15]}}, dp} : {{16{dp[7]}}, dp[7:0]});
  endfunction : tgt
  function automatic logic [7:0] flg(input logic [7:0] o, s, input logic [15:0] f,
                                     input logic [10:0] op);
    logic [7:0] n;
    logic [4:0] res;
    int p[5] = '{0, 2, 4, 6, 7};
    res = {op[7], op[7:0] == 8'h00, op[9], f[15] ? ~^op[7:0] : op[8], op[10]};
    n = o;
    for (int k = 0; k < 5; k++) begin
      case (f[3 * k +: 3])
        3'h1: n[p[k]] = 1'h0;
        3'h2: n[p[k]] = 1'h1;
        3'h3: n[p[k]] = res[k];
        3'h4: n[p[k]] = s[p[k]];
        default: ;
      endcase
    end
    return n;
  endfunction : flg
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int w = rnd() % 4;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (w == 0) s_axi_bready <= 1'h1;
      w--;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int w = rnd() % 4;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (w == 0) s_axi_rready <= 1'h1;
      w--;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // the whole run is a few thousand cycles; this leaves ample margin
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end
  initial begin
    logic [31:0] d, c;
    logic [23:0] ptr [4];
    logic [15:0] sa_t [8];
    logic [15:0] sa, dp, f;
    logic [23:0] ia;
    logic [10:0] op;
    logic [7:0] old, sv, t8;
    logic [1:0] r;
    sa_t = '{16'hfd1f, 16'hfd20, 16'hfdff, 16'hfe00, 16'hfeff, 16'hff00, 16'hff1f, 16'hff20};
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    repeat (2) @(posedge core_clk);
    rd(`OFS_CTRL, d, r);
    chk(d, `RST_CTRL);
    rd(`OFS_PSW, d, r);
    chk(d, 32'h0);
    $display("reset values done");
    for (int k = 0; k < 4; k++) begin
      ptr[k] = 24'(rnd());
      wr(8'(`OFS_PTR0 + 4 * k), {8'h0, ptr[k]}, r);
    end
    for (int i = 0; i < 64; i++) begin
      c = rnd() & 32'h0000_ffff;
      c[2:0] = 3'(i % 8);
      c[15:13] = 3'(rnd() % 6 + 1);
      sa = sa_t[(i / 8) % 8];
      ia = 24'(rnd());
      dp = 16'(rnd());
      m_ctrl = c;
      m_saddr = sa;
      wr(`OFS_CTRL, c, r);
      chk(r, `RESP_OKAY);
      wr(`OFS_SADDR, {16'h0, sa}, r);
      wr(`OFS_IADDR, {8'h0, ia}, r);
      wr(`OFS_DISP, {16'h0, dp}, r);
      rd(`OFS_LEN, d, r);
      chk(d, {28'h0, m_len});
      rd(`OFS_TARGET, d, r);
      chk(d, {8'h0, tgt(ia, dp, m_len[2:0], c[10])});
      rd(`OFS_PTR_EFF, d, r);
      chk(d, {8'h0, ptr[c[4:3]]});
    end
    $display("length target pointer done");
    rd(`OFS_PSW, d, r);
    old = d[7:0];
    for (int i = 0; i < 24; i++) begin
      f = 16'(rnd());
      sv = 8'(rnd());
      op = 11'(rnd());
      if (i == 0) op[7:0] = 8'h00;
      wr(`OFS_FACT, {16'h0, f}, r);
      wr(`OFS_SAVED, {24'h0, sv}, r);
      wr(`OFS_FOP, {21'h0, op}, r);
      rd(`OFS_PSW, d, r);
      t8 = d[7:0];
      chk(t8 & 8'hd5, flg(old, sv, f, op) & 8'hd5);
      rd(`OFS_SAVED, d, r);
      chk(d, {24'h0, old});
      old = t8;
    end
    $display("flag actions done");
    for (int k = 0; k < 4; k++) begin
      c[12:11] = 2'(k);
      sv = 8'(rnd());
      wr(`OFS_CTRL, c, r);
      rd(`OFS_PSW, d, r);
      f = d[15:0];
      wr(`OFS_XFER, {24'h0, sv}, r);
      rd(`OFS_PSW, d, r);
      chk(d, {16'h0, k == 1 ? {f[15:8], sv} : k == 2 ? {sv, f[7:0]} : f});
    end
    $display("flag byte transfer done");
    wr(8'h40, 32'h1, r);
    chk(r, `RESP_SLVERR);
    wr(8'h06, 32'h1, r);
    chk(r, `RESP_SLVERR);
    rd(8'h41, d, r);
    chk(r, `RESP_SLVERR);
    $display("refused accesses done");
    stop_test();
  end
endmodule : byte_transfer_decode_bench
`default_nettype wire
